// file: pkg/fpp_pkg.sv
/*
  fpp_pkg: constants for the fuse prom programming controller.
  assumes a 25 MHz system clock; all timing counts derive from it.
*/
`default_nettype none
package fpp_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int WORDS  = 1024;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 25;
  localparam int SENSE_GAP_NS   = 10000;   // sense off around address change
  localparam int VERIFY_DLY_NS  = 700;     // after pulse trailing edge
  localparam int PULSE_NS       = 7500;    // programming pulse width
  localparam int PULSE_GAP_NS   = 3000;    // low time keeps duty above 70 %
  localparam int TRAIN_MAX_MS   = 100;     // longest train per bit
  localparam int EXTRA_PULSES   = 4;
  localparam int SENSE_GAP_CYC  = (SENSE_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int VERIFY_DLY_CYC = (VERIFY_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_GAP_CYC  = (PULSE_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int TRAIN_MAX_CYC  = TRAIN_MAX_MS * 1000 * CLK_MHZ;
  localparam int TMR_W          = 24;
  // ------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    FPP_IDLE   = 8'h01,
    FPP_SETUP  = 8'h02,
    FPP_PULSE  = 8'h04,
    FPP_VERIFY = 8'h08,
    FPP_EXTRA  = 8'h10,
    FPP_HOLD   = 8'h20,
    FPP_READ   = 8'h40,
    FPP_DONE   = 8'h80
  } fpp_state_t;
endpackage
`default_nettype wire

// file: hw/fpp_timer.sv
/*
  fpp_timer: loadable down counter with a one-cycle expiry pulse.
  assumes the caller loads it only when a new interval starts.
*/
`timescale 1ns/100ps
`default_nettype none
module fpp_timer #(
  parameter int W = 24
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              expired
);
  logic [W-1:0] cnt_q;
  logic         run_q;
  assign expired = run_q && (cnt_q == '0);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= value;
      run_q <= 1'b1;
    end else if (expired) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hw/fpp_ctrl.sv
/*
  fpp_ctrl: host-side controller that reads and fuse-programs a
  1024 x 8 bipolar prom through its pins.
  assumes external drivers turn pgm_pulse and sense_on into the analog
  current sources, and a comparator gives sense_high (output above 7.5 V).
*/
// Operation
// - programmer disables the chip after setting address, before pulses.
// - address set first, then pulses into the one output of the bit.
// - pulse until sensed one, then four extra pulses, then stop.
// - sense current off 10 us before and after any address change.
// - wait 0.7 us after each pulse trailing edge before sensing.
// - train per bit at most 100 ms, else bit reported failed.
// - bit judged one by sensed voltage against 7.5 V threshold.
`timescale 1ns/100ps
`default_nettype none
module fpp_ctrl
  import fpp_pkg::*;
#(
  parameter int TRAIN_MAX = TRAIN_MAX_CYC,
  parameter int SENSE_GAP = SENSE_GAP_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [2:0]        req_bit,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_fail,
  output logic [ADDR_W-1:0]      prom_addr,
  output logic                   select_low_a_n,
  output logic                   select_low_b_n,
  output logic                   select_high_a,
  output logic                   select_high_b,
  input  wire logic [DATA_W-1:0] prom_data,
  output logic [DATA_W-1:0]      pgm_pulse,
  output logic [DATA_W-1:0]      sense_on,
  input  wire logic              sense_high
);
  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  fpp_state_t        st_q, st_d;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0]        bit_q;
  logic [2:0]        extra_q;
  logic [TMR_W-1:0]  train_q;
  logic [DATA_W-1:0] data_q;
  logic              fail_q;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_exp;
  logic              verified;
  logic              train_over;
  logic              take;
  logic [1:0]        rd_cnt_q;
  logic              ph_q;
  logic              tmr_exp_gap;

  fpp_timer #(.W(TMR_W)) u_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (tmr_load),
    .value   (tmr_val),
    .expired (tmr_exp)
  );

  function automatic logic [DATA_W-1:0] bit_onehot(input logic [2:0] b);
    bit_onehot = DATA_W'(1) << b;
  endfunction

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign take       = req_valid && (st_q == FPP_IDLE);
  assign req_ready  = (st_q == FPP_IDLE);
  // a blown fuse pulls the sensed output below the threshold
  assign verified   = !sense_high;
  assign train_over = (train_q >= TMR_W'(TRAIN_MAX));
  // enabled only while reading; disabled by one low select during programming
  assign select_low_a_n = !(st_q == FPP_READ);
  assign select_low_b_n = 1'b0;
  assign select_high_a  = 1'b1;
  assign select_high_b  = 1'b1;
  assign prom_addr      = addr_q;
  // pulses go only into the selected bit's output
  assign pgm_pulse = (st_q == FPP_PULSE || st_q == FPP_EXTRA) && !tmr_exp_gap
                     ? bit_onehot(bit_q) : '0;
  // sense on only in verify window, never near address changes
  assign sense_on  = (st_q == FPP_VERIFY) ? bit_onehot(bit_q) : '0;
  assign rsp_data  = data_q;
  assign rsp_fail  = fail_q;

  // pulse phase: high for PULSE_CYC then low gap, tracked by phase bit
  assign tmr_exp_gap = ph_q;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    case (st_q)
      FPP_IDLE: begin
        if (take) begin
          st_d     = req_write ? FPP_SETUP : FPP_READ;
          tmr_load = req_write;
          tmr_val  = TMR_W'(SENSE_GAP);
        end
      end
      FPP_SETUP: begin
        if (tmr_exp) begin
          st_d     = FPP_PULSE;
          tmr_load = 1'b1;
          tmr_val  = TMR_W'(PULSE_CYC);
        end
      end
      FPP_PULSE, FPP_EXTRA: begin
        if (tmr_exp && !ph_q) begin
          tmr_load = 1'b1;
          tmr_val  = TMR_W'(st_q == FPP_PULSE ? VERIFY_DLY_CYC : PULSE_GAP_CYC);
          if (st_q == FPP_PULSE) st_d = FPP_VERIFY;
        end else if (tmr_exp && ph_q) begin
          if (extra_q == 3'(EXTRA_PULSES - 1)) begin
            st_d     = FPP_HOLD;
            tmr_val  = TMR_W'(SENSE_GAP);
          end else begin
            tmr_val  = TMR_W'(PULSE_CYC);
          end
          tmr_load = 1'b1;
        end
      end
      FPP_VERIFY: begin
        if (tmr_exp) begin
          tmr_load = 1'b1;
          if (verified) begin
            st_d    = FPP_EXTRA;
            tmr_val = TMR_W'(PULSE_CYC);
          end else if (train_over) begin
            st_d    = FPP_HOLD;
            tmr_val = TMR_W'(SENSE_GAP);
          end else begin
            st_d    = FPP_PULSE;
            tmr_val = TMR_W'(PULSE_CYC);
          end
        end
      end
      FPP_HOLD: if (tmr_exp) st_d = FPP_DONE;
      FPP_READ: if (rd_cnt_q == 2'h3) st_d = FPP_DONE;
      FPP_DONE: st_d = FPP_IDLE;
      default:  st_d = FPP_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= FPP_IDLE;
      ph_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == FPP_EXTRA && tmr_exp) ph_q <= !ph_q;
      else if (st_q != FPP_EXTRA) ph_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q   <= '0;
      bit_q    <= '0;
      extra_q  <= '0;
      train_q  <= '0;
      rd_cnt_q <= '0;
    end else begin
      if (take) begin
        addr_q <= req_addr;
        bit_q  <= req_bit;
      end
      if (st_q == FPP_IDLE) train_q <= '0;
      else if (st_q == FPP_PULSE || st_q == FPP_VERIFY) train_q <= train_q + 1'b1;
      if (st_q != FPP_EXTRA) extra_q <= '0;
      else if (tmr_exp && ph_q) extra_q <= extra_q + 1'b1;
      rd_cnt_q <= (st_q == FPP_READ) ? rd_cnt_q + 1'b1 : 2'h0;
    end
  end

  // ------------------------------------------------------------
  // answer
  // ------------------------------------------------------------
  // read waits four cycles (160 ns) to cover the prom access time
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_q    <= '0;
      fail_q    <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (st_d == FPP_DONE);
      if (st_q == FPP_READ && rd_cnt_q == 2'h3) data_q <= prom_data;
      if (take) fail_q <= 1'b0;
      else if (st_q == FPP_VERIFY && tmr_exp && !verified && train_over)
        fail_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb_chk @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  AST_NO_PULSE_ENABLED: assert property ((pgm_pulse != '0) |-> select_low_a_n)
    else $error("pulse while enabled");
  AST_SENSE_NOT_PULSE: assert property (!((pgm_pulse != '0) && (sense_on != '0)))
    else $error("sense with pulse");
  AST_ONE_BIT: assert property ($onehot0(pgm_pulse))
    else $error("more than one output pulsed");
  // address may move only on the taking edge, out of idle
  AST_ADDR_STABLE: assert property ((st_q != FPP_IDLE) |=> $stable(prom_addr))
    else $error("address moved");
  AST_SENSE_GAP: assert property ($changed(prom_addr) |-> (sense_on == '0) [*8])
    else $error("sense near address");
  // the verify sample must not follow a trailing pulse edge too closely
  AST_VERIFY_DLY: assert property (
    $fell(pgm_pulse != '0) |-> !(st_q == FPP_VERIFY && tmr_exp) [*8])
    else $error("sensed too soon");
  AST_READ_ENABLED: assert property (
    (st_q == FPP_READ) |-> !select_low_a_n && !select_low_b_n && select_high_a && select_high_b)
    else $error("read not enabled");
  AST_EXTRA_FOUR: assert property ((st_q == FPP_EXTRA) |-> extra_q < 3'(EXTRA_PULSES))
    else $error("extra pulses overrun");
  AST_READ_LAT: assert property (take && !req_write |-> ##5 rsp_valid)
    else $error("read answer late");

  COV_READ:  cover property (take && !req_write ##5 rsp_valid);
  COV_PGM:   cover property (st_q == FPP_EXTRA);
  COV_FAIL:  cover property ($rose(fail_q));
endmodule
`default_nettype wire

// file: tb/fpp_prom_model.sv
/*
  fpp_prom_model: behavioural 1024 x 8 fuse prom with its program port.
  assumes the controller's pins and its clock, sampled on rising edges.
*/
`timescale 1ns/100ps
`default_nettype none
module fpp_prom_model
  import fpp_pkg::*;
#(
  parameter int GAP   = SENSE_GAP_CYC,
  parameter int BLOWS = 6
) (
  input  wire logic              sys_clk,
  input  wire logic [ADDR_W-1:0] prom_addr,
  input  wire logic              select_low_a_n,
  input  wire logic              select_low_b_n,
  input  wire logic              select_high_a,
  input  wire logic              select_high_b,
  input  wire logic [DATA_W-1:0] pgm_pulse,
  input  wire logic [DATA_W-1:0] sense_on,
  input  wire logic              stubborn,
  output logic [DATA_W-1:0]      prom_data,
  output logic                   sense_high,
  output logic                   viol,
  output logic [7:0]             extra_cnt
);
  // ------------------------------------------------------------
  // array and read path
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] last_q, pulse_q, bit_q;
  logic [ADDR_W-1:0] addr_q;
  logic              enabled;
  int                blows, since_sense, since_addr, since_pulse;
  assign enabled = !select_low_a_n && !select_low_b_n && select_high_a && select_high_b;
  // disabled outputs float, so show the inverse rather than stale data
  assign prom_data = enabled ? mem[prom_addr] : ~last_q;
  // unblown fuse clamps high; too early a look gives a misleading low
  assign sense_high = (|(sense_on & ~mem[prom_addr])) && since_pulse >= VERIFY_DLY_CYC;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {last_q, pulse_q, bit_q, addr_q, viol, extra_cnt} = '0;
    {blows, since_sense, since_addr, since_pulse} = {32'd1000, 32'd1000, 32'd1000, 32'd1000};
  end
  // ------------------------------------------------------------
  // fuse blowing and programmer timing watch
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (enabled) last_q <= mem[prom_addr];
    since_pulse <= (|pgm_pulse) ? 0 : since_pulse + 1;
    since_sense <= (|sense_on) ? 0 : since_sense + 1;
    since_addr <= (prom_addr != addr_q) ? 0 : since_addr + 1;
    addr_q <= prom_addr;
    pulse_q <= pgm_pulse;
    if (prom_addr != addr_q && (since_sense < GAP - 1 || |sense_on)) viol <= 1'b1;
    if (|sense_on && since_addr < GAP - 1) viol <= 1'b1;
    if (|(pgm_pulse & ~pulse_q)) begin
      if (enabled || $countones(pgm_pulse) != 1) viol <= 1'b1;
      if (pgm_pulse != bit_q || prom_addr != addr_q) begin
        blows = 0;
        extra_cnt = 8'h00;
      end
      bit_q <= pgm_pulse;
      blows = blows + 1;
      if (|(mem[prom_addr] & pgm_pulse)) extra_cnt = extra_cnt + 8'h01;
      else if (blows >= BLOWS && !stubborn) mem[prom_addr] <= mem[prom_addr] | pgm_pulse;
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
  testbench: drives fpp_ctrl against the prom model, reads and programs.
  assumes shortened train and sense-gap counts; all else at full size.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fpp_pkg::*;
  localparam int TRAIN = 2000;
  localparam int SG    = 20;
  logic              sys_clk, sys_rst, req_valid, req_ready, req_write, rsp_valid, rsp_fail;
  logic [ADDR_W-1:0] req_addr, prom_addr;
  logic [2:0]        req_bit;
  logic [DATA_W-1:0] rsp_data, prom_data, pgm_pulse, sense_on, acc;
  logic              select_low_a_n, select_low_b_n, select_high_a, select_high_b;
  logic              sense_high, stubborn, viol, en_seen, busy_seen;
  logic [7:0]        extra_cnt;
  int                errors, n_compared, lat;
  fpp_ctrl #(.TRAIN_MAX(TRAIN), .SENSE_GAP(SG)) fpp_ctrl_inst (.*);
  fpp_prom_model #(.GAP(SG), .BLOWS(6)) fpp_prom_model_inst (.*);
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // request held over the taking edge, then wait for the answer
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [2:0] b);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_bit = b;
    @(negedge sys_clk);
    req_valid = 1'b0;
    lat = 1;
    en_seen = !select_low_a_n;
    busy_seen = !req_ready;
    while (rsp_valid !== 1'b1 && lat < 20000) begin
      @(negedge sys_clk);
      lat++;
      en_seen |= !select_low_a_n;
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    req(1'b0, a, 3'h0);
    check(rsp_data, exp);
    check(lat, 5);
    check(en_seen, 1'b1);
    check(busy_seen, 1'b1);
  endtask
  task automatic pg(input logic [ADDR_W-1:0] a, input logic [2:0] b, input logic fail);
    req(1'b1, a, b);
    check(rsp_fail, fail);
    check(en_seen, 1'b0);
    check(lat < TRAIN + 4 * SG + 1500, 1'b1);
    if (!fail) check(extra_cnt, 8'h04);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check({req_ready, select_low_a_n, pgm_pulse, sense_on}, {2'b11, 16'h0000});
    check({select_low_b_n, select_high_a, select_high_b}, 3'b011);
  endtask
  task automatic t_blank_and_decode;
    rd(10'h000, 8'h00);
    rd(10'h3FF, 8'h00);
    pg(10'h3FF, 3'h7, 1'b0);
    rd(10'h3FF, 8'h80);
    rd(10'h3FE, 8'h00);
    rd(10'h1FF, 8'h00);
  endtask
  // every output line in turn, one word, back-to-back requests
  task automatic t_all_bits;
    acc = 8'h00;
    for (int b = 0; b < DATA_W; b++) begin
      pg(10'h155, b[2:0], 1'b0);
      acc[b] = 1'b1;
      rd(10'h155, acc);
    end
  endtask
  // fuse that never opens: train must end and report, then a retry heals
  task automatic t_fail;
    stubborn = 1'b1;
    pg(10'h002, 3'h1, 1'b1);
    stubborn = 1'b0;
    rd(10'h002, 8'h00);
    pg(10'h002, 3'h1, 1'b0);
    rd(10'h002, 8'h02);
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {errors, n_compared} = '0;
    {req_valid, req_write, req_addr, req_bit, stubborn} = '0;
    sys_rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    t_reset();
    sys_rst = 1'b0;
    t_blank_and_decode();
    t_all_bits();
    t_fail();
    check(viol, 1'b0);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
